// ### dlpcs_top.sv
// Configuration and status registers of the single-wire debug link physical layer
`timescale 1ns/1ps
module dlpcs_top
  import dlpcs_pkg::*;
#(
  parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register access from link instruction decoder
  input wire dlpcs_req_t req,
  output logic [7:0] rdata,
  // Physical layer error events and access handshake
  input wire dlpcs_phy_err_t phy_err,
  input wire logic acc_request,
  input wire logic acc_response,
  input wire logic xfer_active,
  // Transmit sequencing
  input wire logic tx_first_req,
  input wire logic tx_next_req,
  input wire logic resp_sig_req,
  output logic tx_line_idle,
  output logic tx_go,
  output logic resp_sig_en,
  output logic nack_send,
  // Settings and link control
  output dlpcs_cfg_t cfg,
  output logic link_enabled,
  output logic link_reset,
  output logic [1:0] link_clock_sel,
  // System domain
  input wire logic sys_sleep_pin,
  input wire logic sys_reset_pin,
  input wire logic [2:0] mem_check_pin,
  output logic sys_clock_request,
  output logic sys_bus_allow,
  output logic sys_reset_request
);

  // Synchronisers for system-domain levels
  logic [1:0] sleep_sync_q, reset_sync_q;
  logic [2:0] mcheck_s1_q, mcheck_s2_q;
  logic sys_asleep, sys_in_reset, sys_in_reset_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_sync_q <= '0;
      reset_sync_q <= '0;
      mcheck_s1_q <= '0;
      mcheck_s2_q <= '0;
      sys_in_reset_q <= 1'b0;
    end else begin
      sleep_sync_q <= {sleep_sync_q[0], sys_sleep_pin};
      reset_sync_q <= {reset_sync_q[0], sys_reset_pin};
      mcheck_s1_q <= mem_check_pin;
      mcheck_s2_q <= mcheck_s1_q;
      sys_in_reset_q <= sys_in_reset;
    end
  end

  assign sys_asleep = sleep_sync_q[1];
  assign sys_in_reset = reset_sync_q[1] | sys_reset_request;

  // Register state
  logic [7:0] ctrl_a_q, ctrl_a_d;
  logic [7:0] ctrl_b_q, ctrl_b_d;
  logic [2:0] err_q, err_d;
  logic system_clock_request_q, system_clock_request_d;
  logic rst_req_q, rst_req_d;
  logic [1:0] clksel_q, clksel_d;
  logic disable_q, disable_d;
  logic [16:0] tmo_q, tmo_d;
  logic tmo_run_q, tmo_run_d;
  logic tmo_hit;
  logic [2:0] err_event;
  logic err_rd;

  // Reads come only from link instructions; there is no CPU port at all
  assign err_rd = req.rd && (req.addr == REG_ERROR_SIGNATURE);

  // Error event priority: contention over time-out over framing over clock recovery over parity
  always_comb begin
    err_event = ERR_NONE;
    if (phy_err.parity && !cfg.parity_check_disable) begin
      err_event = ERR_PARITY;
    end
    if (phy_err.clock_recovery) begin
      err_event = ERR_CLOCK_RECOVERY;
    end
    if (phy_err.frame) begin
      err_event = ERR_FRAME;
    end
    if (tmo_hit) begin
      err_event = ERR_TIMEOUT;
    end
    if (phy_err.contention && !cfg.collision_detect_disable) begin
      err_event = ERR_CONTENTION;
    end
  end

  // Access layer time-out counter
  always_comb begin
    tmo_d = tmo_q;
    tmo_run_d = tmo_run_q;
    tmo_hit = 1'b0;
    if (link_reset || acc_response || cfg.timeout_detect_disable) begin
      tmo_run_d = 1'b0;
      tmo_d = '0;
    end else if (acc_request && !tmo_run_q) begin
      tmo_run_d = 1'b1;
      tmo_d = '0;
    end else if (tmo_run_q) begin
      if (tmo_q == 17'(TIMEOUT_LIMIT - 1)) begin
        tmo_hit = 1'b1;
        tmo_run_d = 1'b0;
      end
      tmo_d = tmo_q + 17'h00001;
    end
  end

  // Register writes and read side effects
  always_comb begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    err_d = err_q;
    system_clock_request_d = system_clock_request_q;
    rst_req_d = rst_req_q;
    clksel_d = clksel_q;
    disable_d = 1'b0;
    if (err_rd) begin
      err_d = ERR_NONE;
    end
    // An error in the read cycle survives the clear
    if (err_event != ERR_NONE) begin
      err_d = err_event;
    end
    if (req.wr) begin
      unique case (req.addr)
        REG_CONTROL_FIRST: ctrl_a_d = req.wdata & CTRL_FIRST_MASK;
        REG_CONTROL_SECOND: begin
          ctrl_b_d = req.wdata & CTRL_SECOND_MASK;
          disable_d = req.wdata[DIS_BIT];
        end
        REG_SYS_RESET_REQ: rst_req_d = (req.wdata == SYS_RESET_SIGNATURE);
        REG_CLOCK_SELECT: clksel_d = req.wdata[1:0];
        REG_SYS_ACCESS_CTRL: system_clock_request_d = req.wdata[SYSTEM_CLOCK_REQUEST_BIT];
        default: ;
      endcase
    end
    // Disabling wipes configuration and drops the clock request
    if (disable_q) begin
      ctrl_a_d = CTRL_RESET;
      ctrl_b_d = CTRL_RESET;
      err_d = ERR_NONE;
      system_clock_request_d = 1'b0;
      clksel_d = CLKSEL_RESET;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a_q <= CTRL_RESET;
      ctrl_b_q <= CTRL_RESET;
      err_q <= ERR_NONE;
      system_clock_request_q <= SYSTEM_CLOCK_REQUEST_RESET;
      rst_req_q <= 1'b0;
      clksel_q <= CLKSEL_RESET;
      disable_q <= 1'b0;
      tmo_q <= '0;
      tmo_run_q <= 1'b0;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      err_q <= err_d;
      system_clock_request_q <= system_clock_request_d;
      rst_req_q <= rst_req_d;
      clksel_q <= clksel_d;
      disable_q <= disable_d;
      tmo_q <= tmo_d;
      tmo_run_q <= tmo_run_d;
    end
  end

  // Settings out
  always_comb begin
    cfg.inter_byte_delay_enable = ctrl_a_q[IBD_BIT];
    cfg.parity_check_disable = ctrl_a_q[PARITY_CHECK_DISABLE_BIT];
    cfg.timeout_detect_disable = ctrl_a_q[DTD_BIT];
    cfg.response_signature_disable = ctrl_a_q[RSD_BIT];
    cfg.guard_time_select = ctrl_a_q[GT_LSB +: 3];
    cfg.nack_suppress = ctrl_b_q[NACK_BIT];
    cfg.collision_detect_disable = ctrl_b_q[CCD_BIT];
  end

  // Link keeps its own clock regardless of system sleep state
  assign link_enabled = !disable_q;
  assign link_reset = disable_q;
  assign link_clock_sel = clksel_q;
  assign sys_clock_request = system_clock_request_q && !disable_q;
  // Uses the request as seen outside, so a disable pulse also withholds bus access while the system sleeps
  assign sys_bus_allow = !sys_asleep || sys_clock_request;
  assign sys_reset_request = rst_req_q;
  assign resp_sig_en = resp_sig_req && !cfg.response_signature_disable;
  // System reset rising during a load or store transfer
  assign nack_send = sys_in_reset && !sys_in_reset_q && xfer_active && !cfg.nack_suppress;

  // Read mux; access-layer registers follow the physical ones
  always_comb begin
    rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        REG_REVISION_STATUS: rdata = {LINK_REVISION, 4'h0};
        REG_ERROR_SIGNATURE: rdata = {5'h00, err_q};
        REG_CONTROL_FIRST: rdata = ctrl_a_q;
        REG_CONTROL_SECOND: rdata = ctrl_b_q;
        REG_SYS_RESET_REQ: rdata = {7'h00, rst_req_q};
        REG_CLOCK_SELECT: rdata = {6'h00, clksel_q};
        REG_SYS_ACCESS_CTRL: rdata = {7'h00, system_clock_request_q};
        REG_SYS_DOMAIN_STATE: begin
          rdata[ASLEEP_BIT] = sys_asleep;
        end
        REG_MEM_CHECK_STATE: rdata = {5'h00, mcheck_s2_q};
        default: rdata = 8'h00;
      endcase
    end
  end

  dlpcs_gap_timer u_gap (
    .clk(clk),
    .arst_n(arst_n),
    .link_reset(link_reset),
    .cfg(cfg),
    .tx_first_req(tx_first_req),
    .tx_next_req(tx_next_req),
    .tx_line_idle(tx_line_idle),
    .tx_go(tx_go)
  );

endmodule

// ### dlpcs_pkg.sv
// Package with register map, field layout and timing constants for the debug link configuration block
package dlpcs_pkg;

  // Register offsets in link register space
  localparam logic [3:0] REG_REVISION_STATUS = 4'h0;
  localparam logic [3:0] REG_ERROR_SIGNATURE = 4'h1;
  localparam logic [3:0] REG_CONTROL_FIRST = 4'h2;
  localparam logic [3:0] REG_CONTROL_SECOND = 4'h3;
  localparam logic [3:0] REG_ACCESS_FIRST = 4'h4;
  localparam logic [3:0] REG_ACCESS_LAST = 4'hC;
  localparam logic [3:0] REG_UNLOCK_KEY = 4'h7;
  localparam logic [3:0] REG_SYS_RESET_REQ = 4'h8;
  localparam logic [3:0] REG_CLOCK_SELECT = 4'h9;
  localparam logic [3:0] REG_SYS_ACCESS_CTRL = 4'hA;
  localparam logic [3:0] REG_SYS_DOMAIN_STATE = 4'hB;
  localparam logic [3:0] REG_MEM_CHECK_STATE = 4'hC;

  // Revision value is arbitrary
  localparam logic [3:0] LINK_REVISION = 4'h3;
  localparam int REV_LSB = 4;

  // First control register fields
  localparam int IBD_BIT = 7;
  localparam int PARITY_CHECK_DISABLE_BIT = 5;
  localparam int DTD_BIT = 4;
  localparam int RSD_BIT = 3;
  localparam int GT_LSB = 0;
  // Second control register fields
  localparam int NACK_BIT = 4;
  localparam int CCD_BIT = 3;
  localparam int DIS_BIT = 2;
  localparam logic [7:0] CTRL_FIRST_MASK = 8'hBF;
  localparam logic [7:0] CTRL_SECOND_MASK = 8'h18;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // System access control and domain state fields
  localparam int SYSTEM_CLOCK_REQUEST_BIT = 0;
  localparam int ASLEEP_BIT = 4;
  localparam logic SYSTEM_CLOCK_REQUEST_RESET = 1'b1;
  localparam logic [7:0] SYS_RESET_SIGNATURE = 8'h59;
  localparam logic [1:0] CLKSEL_RESET = 2'h3;

  // Error signature codes
  typedef enum logic [2:0] {
    ERR_NONE = 3'h0,
    ERR_PARITY = 3'h1,
    ERR_FRAME = 3'h2,
    ERR_TIMEOUT = 3'h3,
    ERR_CLOCK_RECOVERY = 3'h4,
    ERR_CONTENTION = 3'h7
  } dlpcs_err_t;

  // Timing in link clock cycles
  localparam int TIMEOUT_CYCLES = 65536;
  localparam int GT_MAX_CYCLES = 128;
  localparam logic [2:0] GT_OFF = 3'h7;
  localparam int IDLE_CHAR_BITS = 12;
  localparam int IBD_CHARS = 2;
  localparam logic [7:0] IBD_CYCLES = 8'(IDLE_CHAR_BITS * IBD_CHARS);
  localparam logic [7:0] ONE_CYCLE = 8'h01;

  // Register access from the link instruction decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dlpcs_req_t;

  // Events reported by the physical layer
  typedef struct packed {
    logic parity;
    logic frame;
    logic clock_recovery;
    logic contention;
  } dlpcs_phy_err_t;

  // Settings handed to the physical layer
  typedef struct packed {
    logic inter_byte_delay_enable;
    logic parity_check_disable;
    logic timeout_detect_disable;
    logic response_signature_disable;
    logic [2:0] guard_time_select;
    logic nack_suppress;
    logic collision_detect_disable;
  } dlpcs_cfg_t;

endpackage

// ### dlpcs_gap_timer.sv
// Turnaround gap timer: guard time before first byte, inter-byte delay after others
`timescale 1ns/1ps
module dlpcs_gap_timer
  import dlpcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_reset,
  // Settings
  input wire dlpcs_cfg_t cfg,
  // Transmit sequencing
  input wire logic tx_first_req,
  input wire logic tx_next_req,
  output logic tx_line_idle,
  output logic tx_go
);

  logic [7:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic [7:0] gt_len;

  // Code 0 gives the longest gap, each step up to code 6 halves it, code 7 gives no gap
  always_comb begin
    gt_len = 8'(GT_MAX_CYCLES) >> cfg.guard_time_select;
  end

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    tx_go = 1'b0;
    if (link_reset) begin
      busy_d = 1'b0;
      cnt_d = '0;
    end else if (busy_q) begin
      if (cnt_q == ONE_CYCLE) begin
        busy_d = 1'b0;
        tx_go = 1'b1;
      end
      cnt_d = cnt_q - ONE_CYCLE;
    end else if (tx_first_req) begin
      if (cfg.guard_time_select == GT_OFF) begin
        tx_go = 1'b1;
      end else begin
        busy_d = 1'b1;
        cnt_d = gt_len;
      end
    end else if (tx_next_req) begin
      if (cfg.inter_byte_delay_enable) begin
        busy_d = 1'b1;
        cnt_d = IBD_CYCLES;
      end else begin
        tx_go = 1'b1;
      end
    end
  end

  // Line is held idle while the gap runs
  assign tx_line_idle = busy_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule

// ### dlpcs_props.sv
// Checker for the debug link configuration block
`timescale 1ns/1ps
module dlpcs_props
  import dlpcs_pkg::*;
#(
  parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register access and events
  input wire dlpcs_req_t req,
  input wire logic [7:0] rdata,
  input wire dlpcs_phy_err_t phy_err,
  input wire logic xfer_active,
  // Transmit sequencing
  input wire logic tx_first_req,
  input wire logic tx_next_req,
  input wire logic resp_sig_req,
  input wire logic tx_line_idle,
  input wire logic tx_go,
  input wire logic resp_sig_en,
  input wire logic nack_send,
  // Settings and system domain
  input wire dlpcs_cfg_t cfg,
  input wire logic link_reset,
  input wire logic sys_sleep_pin,
  input wire logic sys_clock_request,
  input wire logic sys_bus_allow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  rev_read_a: assert property (
    req.rd && req.addr == REG_REVISION_STATUS |-> rdata[7:4] == LINK_REVISION)
    else $error("revision field wrong");
  parity_sig_a: assert property (
    phy_err == 4'h8 && !cfg.parity_check_disable ##2 req.rd && req.addr == REG_ERROR_SIGNATURE
    |-> rdata[2:0] == ERR_PARITY)
    else $error("parity signature missing");
  gt_off_a: assert property (
    tx_first_req && cfg.guard_time_select == GT_OFF |-> tx_go)
    else $error("byte held with guard time off");
  gt_short_a: assert property (
    tx_first_req && cfg.guard_time_select == 3'h6 |-> !tx_go ##1 (tx_line_idle && !tx_go) ##1 tx_go)
    else $error("two cycle guard time wrong");
  ibd_off_a: assert property (
    tx_next_req && !cfg.inter_byte_delay_enable |-> tx_go)
    else $error("next byte delayed");
  ibd_on_a: assert property (
    tx_next_req && cfg.inter_byte_delay_enable |-> !tx_go ##24 tx_go)
    else $error("inter byte delay wrong");
  resp_gate_a: assert property (
    resp_sig_en == (resp_sig_req && !cfg.response_signature_disable))
    else $error("response signature gate wrong");
  nack_gate_a: assert property (
    nack_send |-> xfer_active && !cfg.nack_suppress)
    else $error("nack sent when not allowed");
  sleep_bus_a: assert property (
    sys_sleep_pin [*3] ##0 !sys_clock_request |-> !sys_bus_allow)
    else $error("bus allowed while asleep");
  link_off_a: assert property (
    req.wr && req.addr == REG_CONTROL_SECOND && req.wdata[DIS_BIT]
    |=> link_reset ##1 (cfg == '0 && !sys_clock_request))
    else $error("link disable incomplete");

  cover property (tx_first_req ##[1:200] tx_go);
  cover property (nack_send);
  cover property (link_reset);
endmodule

bind dlpcs_top dlpcs_props #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) props_u (.clk(clk), .arst_n(arst_n), .req(req),
  .rdata(rdata), .phy_err(phy_err), .xfer_active(xfer_active), .tx_first_req(tx_first_req),
  .tx_next_req(tx_next_req), .resp_sig_req(resp_sig_req), .tx_line_idle(tx_line_idle), .tx_go(tx_go),
  .resp_sig_en(resp_sig_en), .nack_send(nack_send), .cfg(cfg), .link_reset(link_reset),
  .sys_sleep_pin(sys_sleep_pin), .sys_clock_request(sys_clock_request), .sys_bus_allow(sys_bus_allow));

// ### dlpcs_debugger.sv
// Debugger model issuing link register instructions
`timescale 1ns/1ps
module dlpcs_debugger
  import dlpcs_pkg::*;
(
  // Link side
  input wire logic clk,
  output dlpcs_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  // Registers are reached only through these instructions
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask
  // Answer is taken at the edge that samples the request
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    d = rdata;
    @(negedge clk);
    req = '0;
  endtask
endmodule

// ### testbench.sv
// Self-checking testbench for the debug link configuration block
`timescale 1ns/1ps
module testbench;
  import dlpcs_pkg::*;
  // Short time-out keeps the run brief
  localparam int TL = 16;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  dlpcs_req_t req;
  logic [7:0] rdata;
  dlpcs_phy_err_t phy_err = '0;
  logic acc_request = 1'b0;
  logic acc_response = 1'b0;
  logic xfer_active = 1'b0;
  logic tx_first_req = 1'b0;
  logic tx_next_req = 1'b0;
  logic resp_sig_req = 1'b0;
  logic sys_sleep_pin = 1'b0;
  logic sys_reset_pin = 1'b0;
  logic [2:0] mem_check_pin = 3'h2;
  logic tx_line_idle, tx_go, resp_sig_en, nack_send, link_enabled, link_reset;
  logic sys_clock_request, sys_bus_allow, sys_reset_request;
  logic [1:0] link_clock_sel;
  dlpcs_cfg_t cfg;
  int mismatches = 0;
  int n_compared = 0;
  int i;
  logic [3:0] ra[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
  logic [7:0] rv[10] = '{{LINK_REVISION, 4'h0}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h00, 8'h02};
  logic [7:0] codes[4] = '{8'(ERR_PARITY), 8'(ERR_FRAME), 8'(ERR_CLOCK_RECOVERY), 8'(ERR_CONTENTION)};

  initial forever #25 clk = ~clk;

  dlpcs_top #(.TIMEOUT_LIMIT(TL)) dut_u (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
    .phy_err(phy_err), .acc_request(acc_request), .acc_response(acc_response), .xfer_active(xfer_active),
    .tx_first_req(tx_first_req), .tx_next_req(tx_next_req), .resp_sig_req(resp_sig_req),
    .tx_line_idle(tx_line_idle), .tx_go(tx_go), .resp_sig_en(resp_sig_en), .nack_send(nack_send),
    .cfg(cfg), .link_enabled(link_enabled), .link_reset(link_reset), .link_clock_sel(link_clock_sel),
    .sys_sleep_pin(sys_sleep_pin), .sys_reset_pin(sys_reset_pin), .mem_check_pin(mem_check_pin),
    .sys_clock_request(sys_clock_request), .sys_bus_allow(sys_bus_allow),
    .sys_reset_request(sys_reset_request));
  dlpcs_debugger dbg_u (.clk(clk), .req(req), .rdata(rdata));

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    dbg_u.rd(a, d);
    chk(d, exp);
  endtask
  task automatic errp(input logic [3:0] e);
    @(negedge clk);
    phy_err = dlpcs_phy_err_t'(e);
    @(negedge clk);
    phy_err = '0;
  endtask
  // Counts cycles from the byte request to the go pulse, and the idle-line cycles on the way
  task automatic gap(input logic first, input int exp);
    int k;
    int idle;
    idle = 0;
    @(negedge clk);
    tx_first_req = first;
    tx_next_req = !first;
    #1;
    for (k = 0; k < 200 && tx_go !== 1'b1; k++) begin
      @(negedge clk);
      tx_first_req = 1'b0;
      tx_next_req = 1'b0;
      #1;
      idle += (tx_line_idle === 1'b1);
    end
    @(negedge clk);
    tx_first_req = 1'b0;
    tx_next_req = 1'b0;
    if (k == 200) begin
      mismatches++;
      end_of_test();
    end else begin
      chk(8'(k), 8'(exp));
      chk(8'(idle), 8'(exp));
    end
  endtask
  // Error, time-out, signature and nack behaviour with checks off or on
  task automatic events(input logic dis);
    int j;
    int c;
    for (j = 0; j < 4; j++) begin
      errp(4'h8 >> j);
      rchk(REG_ERROR_SIGNATURE, (dis && (j == 0 || j == 3)) ? 8'h00 : codes[j]);
      rchk(REG_ERROR_SIGNATURE, 8'h00);
    end
    @(negedge clk);
    acc_request = 1'b1;
    @(negedge clk);
    acc_request = 1'b0;
    repeat (TL - 4) @(negedge clk);
    rchk(REG_ERROR_SIGNATURE, 8'h00);
    repeat (6) @(negedge clk);
    rchk(REG_ERROR_SIGNATURE, dis ? 8'h00 : 8'(ERR_TIMEOUT));
    resp_sig_req = 1'b1;
    #1;
    chk(resp_sig_en, !dis);
    resp_sig_req = 1'b0;
    xfer_active = 1'b1;
    sys_reset_pin = 1'b1;
    c = 0;
    repeat (6) begin
      @(negedge clk);
      c += nack_send;
    end
    chk(8'(c), dis ? 8'h00 : 8'h01);
    sys_reset_pin = 1'b0;
    xfer_active = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    for (i = 0; i < 10; i++) rchk(ra[i], rv[i]);
    chk(sys_clock_request, 1'b1);
    chk(link_enabled, 1'b1);
    chk(link_clock_sel, 8'(CLKSEL_RESET));
    dbg_u.wr(REG_REVISION_STATUS, 8'hFF);
    dbg_u.wr(REG_CONTROL_FIRST, 8'hFF);
    dbg_u.wr(REG_CONTROL_SECOND, 8'h18);
    dbg_u.wr(4'h5, 8'hFF);
    rchk(REG_REVISION_STATUS, {LINK_REVISION, 4'h0});
    rchk(REG_CONTROL_FIRST, CTRL_FIRST_MASK);
    rchk(REG_CONTROL_SECOND, 8'h18);
    rchk(4'h5, 8'h00);
    dbg_u.wr(REG_CONTROL_FIRST, 8'h38);
    events(1'b1);
    dbg_u.wr(REG_CONTROL_FIRST, 8'h00);
    dbg_u.wr(REG_CONTROL_SECOND, 8'h00);
    events(1'b0);
    for (i = 0; i < 8; i++) begin
      dbg_u.wr(REG_CONTROL_FIRST, 8'(i));
      gap(1'b1, i == 7 ? 0 : GT_MAX_CYCLES >> i);
    end
    gap(1'b0, 0);
    dbg_u.wr(REG_CONTROL_FIRST, 8'h80);
    gap(1'b1, GT_MAX_CYCLES);
    gap(1'b0, IBD_CYCLES);
    sys_sleep_pin = 1'b1;
    repeat (4) @(negedge clk);
    rchk(REG_SYS_DOMAIN_STATE, 8'h10);
    chk(sys_bus_allow, 1'b1);
    dbg_u.wr(REG_SYS_ACCESS_CTRL, 8'h00);
    chk(sys_bus_allow, 1'b0);
    dbg_u.wr(REG_SYS_ACCESS_CTRL, 8'h01);
    sys_sleep_pin = 1'b0;
    dbg_u.wr(REG_SYS_RESET_REQ, SYS_RESET_SIGNATURE);
    rchk(REG_SYS_RESET_REQ, 8'h01);
    chk(sys_reset_request, 1'b1);
    dbg_u.wr(REG_CLOCK_SELECT, 8'h01);
    chk(link_clock_sel, 8'h01);
    dbg_u.wr(REG_CONTROL_FIRST, 8'hBF);
    dbg_u.wr(REG_CONTROL_SECOND, 8'h1C);
    // The disable pulse stands in the cycle after the write edge
    chk(link_reset, 1'b1);
    chk(link_enabled, 1'b0);
    rchk(REG_CONTROL_FIRST, 8'h00);
    chk(sys_clock_request, 1'b0);
    chk(link_reset, 1'b0);
    chk(link_clock_sel, 8'(CLKSEL_RESET));
    end_of_test();
  end
endmodule
